/* shared/oag_pkg.sv */
// operand address generator: shared constants, types and carriers
package oag_pkg;
    // special function register map
    localparam logic [7:0] STATUS_ADDR = 8'hd0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int BANK_HI = 4;
    localparam int BANK_LO = 3;
    // register area layout
    localparam logic [7:0] DIRECT_TOP = 8'h7f;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [2:0] BIT_SFR_LOW = 3'h0;
    localparam logic [7:0] RAM_DEPTH_LOG = 8'h08;
    // clocking
    localparam logic [1:0] CLK_PER_MC_LAST = 2'h3;
    localparam logic [3:0] TMR_CLK_LAST = 4'hb;
    // machine cycle counts per class
    localparam logic [2:0] CYC_MIN = 3'h1;
    localparam logic [2:0] CYC_MAX = 3'h5;
    localparam logic [2:0] CYC_REG = 3'h1;
    localparam logic [2:0] CYC_MULT = 3'h5;
    localparam logic [2:0] CYC_DIV = 3'h5;
    localparam logic [2:0] CYC_TABLE = 3'h3;
    localparam logic [2:0] CYC_XMOVE = 3'h2;
    localparam logic [2:0] CYC_BRANCH = 3'h3;
    // fetch decision
    localparam logic [15:0] ONCHIP_TOP_DEF = 16'h0fff;

    typedef enum logic [3:0] {
        OAG_REG = 4'b0000,
        OAG_DIRECT = 4'b0001,
        OAG_BIT = 4'b0010,
        OAG_INDIRECT = 4'b0011,
        OAG_STACK = 4'b0100,
        OAG_IMM = 4'b0101,
        OAG_XRI = 4'b0110,
        OAG_XPTR = 4'b0111,
        OAG_TAB_PC = 4'b1000,
        OAG_TAB_PTR = 4'b1001,
        OAG_REL = 4'b1010,
        OAG_PAGE = 4'b1011,
        OAG_LONG = 4'b1100
    } oag_mode_t;

    typedef enum logic [2:0] {
        OAG_GENERIC = 3'b000,
        OAG_MULT = 3'b001,
        OAG_DIV = 3'b010,
        OAG_TABLE = 3'b011,
        OAG_XMOVE = 3'b100,
        OAG_BRANCH = 3'b101
    } oag_class_t;

    typedef enum logic [2:0] {
        OAG_SP_NONE = 3'b000,
        OAG_SP_IRAM = 3'b001,
        OAG_SP_SFR = 3'b010,
        OAG_SP_XDATA = 3'b011,
        OAG_SP_CODE = 3'b100,
        OAG_SP_IMM = 3'b101
    } oag_space_t;

    typedef struct packed {
        oag_mode_t mode;
        oag_class_t cls;
        logic [2:0] len;
        logic [2:0] reg_sel;
        logic [7:0] op1;
        logic [7:0] op2;
        logic cond;
    } oag_req_t;

    typedef struct packed {
        oag_space_t space;
        logic [15:0] addr;
        logic [2:0] bitpos;
        logic bit_op;
        logic acc_dest;
    } oag_res_t;
endpackage

/* logic/oag_mcycle.sv */
// machine cycle phase, address latch pulse and legacy timer tick
`timescale 1ns/1ps
module oag_mcycle (
    input wire logic clk_i,
    input wire logic reset_i,
    output logic ale_o,
    output logic timer_tick_o
);
    logic [1:0] phase;
    logic [3:0] tcnt;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase <= 2'h0;
            ale_o <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            ale_o <= (phase == oag_pkg::CLK_PER_MC_LAST);
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tcnt <= 4'h0;
            timer_tick_o <= 1'b0;
        end else begin
            tcnt <= (tcnt == oag_pkg::TMR_CLK_LAST) ? 4'h0 : tcnt + 4'h1;
            timer_tick_o <= (tcnt == oag_pkg::TMR_CLK_LAST);
        end
    end

    AST_ALE_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
        ale_o |=> !ale_o [*3] ##1 ale_o) else $error("ale period is not four clocks");
    AST_TIMER_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
        timer_tick_o |=> !timer_tick_o [*8] ##1 !timer_tick_o [*3] ##1 timer_tick_o)
        else $error("timer tick period is not twelve clocks");
endmodule // oag_mcycle

/* logic/oag_scratch_ram.sv */
// scratchpad ram, 256 bytes, one write port and a registered read port
`timescale 1ns/1ps
module oag_scratch_ram (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [7:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:255];

    // no reset on the array; contents are software's business
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // read data registered, one cycle latency
    always_ff @(posedge clk_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule // oag_scratch_ram

/* logic/oag_top.sv */
// operand and branch target address generator with cycle timing
`timescale 1ns/1ps
module oag_top #(
    parameter logic [15:0] ONCHIP_TOP = oag_pkg::ONCHIP_TOP_DEF
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire oag_pkg::oag_req_t req_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] sp_i,
    input wire logic [7:0] p2_i,
    input wire logic [15:0] data_pointer_a_i,
    input wire logic [15:0] data_pointer_b_i,
    input wire logic data_pointer_sel_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic ram_we_i,
    input wire logic [7:0] ram_addr_i,
    input wire logic [7:0] ram_wdata_i,
    output oag_pkg::oag_res_t res_o,
    output logic [15:0] next_pc_o,
    output logic code_onchip_o,
    output logic busy_o,
    output logic done_o,
    output logic [7:0] program_status_word_o,
    output logic ale_o,
    output logic timer_tick_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_CALC = 2'b10,
        ST_RUN = 2'b11
    } oag_state_t;

    oag_state_t state;
    oag_pkg::oag_req_t req_q;
    logic [15:0] pc_q;
    logic [7:0] ram_raddr;
    logic [7:0] ram_rdata;
    logic [2:0] cyc_left;
    logic [2:0] next_cyc;
    logic [1:0] bank;
    logic [15:0] next_seq;
    logic [15:0] next_pc;
    logic [15:0] data_pointer_cur;
    oag_pkg::oag_res_t next_res;

    ////////////////////////////////////////////////////////////////////////////
    // submodules

    oag_mcycle u_mcycle (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ale_o(ale_o),
        .timer_tick_o(timer_tick_o)
    );

    oag_scratch_ram u_ram (
        .clk_i(clk_i),
        .we_i(ram_we_i),
        .waddr_i(ram_addr_i),
        .wdata_i(ram_wdata_i),
        .raddr_i(ram_raddr),
        .rdata_o(ram_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status word register

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            program_status_word_o <= oag_pkg::STATUS_RESET;
        end else if (sfr_wr_i && sfr_addr_i == oag_pkg::STATUS_ADDR) begin
            program_status_word_o <= sfr_wdata_i;
        end
    end

    assign bank = program_status_word_o[oag_pkg::BANK_HI:oag_pkg::BANK_LO];

    ////////////////////////////////////////////////////////////////////////////
    // request capture and sequencing

    // request is held steady for the whole instruction
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_q <= '0;
            pc_q <= 16'h0000;
        end else if (state == ST_IDLE && start_i) begin
            req_q <= req_i;
            pc_q <= pc_i;
        end
    end

    assign ram_raddr = {3'h0, bank, req_q.reg_sel};
    assign data_pointer_cur = data_pointer_sel_i ? data_pointer_b_i : data_pointer_a_i;
    assign next_seq = pc_q + {13'h0000, req_q.len};

    always_comb begin
        case (req_q.cls)
            oag_pkg::OAG_GENERIC: next_cyc = (req_q.mode == oag_pkg::OAG_REG) ? oag_pkg::CYC_REG : req_q.len;
            oag_pkg::OAG_MULT: next_cyc = oag_pkg::CYC_MULT;
            oag_pkg::OAG_DIV: next_cyc = oag_pkg::CYC_DIV;
            oag_pkg::OAG_TABLE: next_cyc = oag_pkg::CYC_TABLE;
            oag_pkg::OAG_XMOVE: next_cyc = oag_pkg::CYC_XMOVE;
            oag_pkg::OAG_BRANCH: next_cyc = oag_pkg::CYC_BRANCH;
            default: next_cyc = req_q.len;
        endcase
        if (next_cyc < oag_pkg::CYC_MIN) begin
            next_cyc = oag_pkg::CYC_MIN;
        end else if (next_cyc > oag_pkg::CYC_MAX) begin
            next_cyc = oag_pkg::CYC_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand address formation

    always_comb begin
        next_res = '0;
        next_pc = next_seq;
        case (req_q.mode)
            oag_pkg::OAG_REG: begin
                next_res.space = oag_pkg::OAG_SP_IRAM;
                next_res.addr = {8'h00, ram_raddr};
            end
            oag_pkg::OAG_DIRECT: begin
                next_res.space = (req_q.op1 > oag_pkg::DIRECT_TOP) ? oag_pkg::OAG_SP_SFR : oag_pkg::OAG_SP_IRAM;
                next_res.addr = {8'h00, req_q.op1};
            end
            oag_pkg::OAG_BIT: begin
                next_res.bit_op = 1'b1;
                next_res.bitpos = req_q.op1[2:0];
                if (req_q.op1[7]) begin
                    next_res.space = oag_pkg::OAG_SP_SFR;
                    next_res.addr = {8'h00, req_q.op1[7:3], oag_pkg::BIT_SFR_LOW};
                end else begin
                    next_res.space = oag_pkg::OAG_SP_IRAM;
                    next_res.addr = {8'h00, oag_pkg::BIT_RAM_BASE + {4'h0, req_q.op1[6:3]}};
                end
            end
            oag_pkg::OAG_INDIRECT: begin
                next_res.space = oag_pkg::OAG_SP_IRAM;
                next_res.addr = {8'h00, ram_rdata};
            end
            oag_pkg::OAG_STACK: begin
                next_res.space = oag_pkg::OAG_SP_IRAM;
                next_res.addr = {8'h00, sp_i};
            end
            oag_pkg::OAG_IMM: begin
                next_res.space = oag_pkg::OAG_SP_IMM;
                next_res.addr = {8'h00, req_q.op1};
            end
            oag_pkg::OAG_XRI: begin
                next_res.space = oag_pkg::OAG_SP_XDATA;
                next_res.addr = {p2_i, ram_rdata};
            end
            oag_pkg::OAG_XPTR: begin
                next_res.space = oag_pkg::OAG_SP_XDATA;
                next_res.addr = data_pointer_cur;
            end
            oag_pkg::OAG_TAB_PC: begin
                next_res.space = oag_pkg::OAG_SP_CODE;
                next_res.addr = next_seq + {8'h00, acc_i};
                next_res.acc_dest = 1'b1;
            end
            oag_pkg::OAG_TAB_PTR: begin
                next_res.space = oag_pkg::OAG_SP_CODE;
                next_res.addr = data_pointer_cur + {8'h00, acc_i};
                next_res.acc_dest = 1'b1;
            end
            oag_pkg::OAG_REL: begin
                if (req_q.cond) begin
                    next_pc = next_seq + {{8{req_q.op1[7]}}, req_q.op1};
                end
            end
            oag_pkg::OAG_PAGE: next_pc = {next_seq[15:11], req_q.op2[2:0], req_q.op1};
            oag_pkg::OAG_LONG: next_pc = {req_q.op2, req_q.op1};
            default: next_res = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // state machine

    // read slot always spent so every mode sees equal latency
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: state <= start_i ? ST_READ : ST_IDLE;
                ST_READ: state <= ST_CALC;
                ST_CALC: state <= ST_RUN;
                ST_RUN: state <= (ale_o && cyc_left == 3'h1) ? ST_IDLE : ST_RUN;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // result and cycle budget registered once per instruction
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            res_o <= '0;
            next_pc_o <= 16'h0000;
            code_onchip_o <= 1'b0;
            cyc_left <= 3'h0;
        end else if (state == ST_CALC) begin
            res_o <= next_res;
            next_pc_o <= next_pc;
            code_onchip_o <= (next_pc <= ONCHIP_TOP);
            cyc_left <= next_cyc;
        end else if (state == ST_RUN && ale_o) begin
            cyc_left <= cyc_left - 3'h1;
        end
    end

    // handshake flags
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            busy_o <= (state == ST_IDLE) ? start_i : !(state == ST_RUN && ale_o && cyc_left == 3'h1);
            done_o <= (state == ST_RUN && ale_o && cyc_left == 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    AST_REG_BANK: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_REG
        |=> res_o.addr == {8'h00, 3'h0, $past(bank), $past(req_q.reg_sel)})
        else $error("register operand not in selected bank");
    AST_DIRECT_SFR: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_DIRECT
        |=> (res_o.space == oag_pkg::OAG_SP_SFR) == ($past(req_q.op1) > 8'h7f))
        else $error("direct split wrong");
    AST_BIT_RAM: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_BIT
        |=> res_o.addr[7:0] inside {[8'h20:8'h2f]} || res_o.addr[2:0] == 3'h0)
        else $error("bit byte outside bit area");
    AST_XRI_PAGE: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_XRI
        |=> res_o.addr[15:8] == $past(p2_i) && res_o.addr[7:0] == $past(ram_rdata))
        else $error("paged external address wrong");
    AST_REL_TARGET: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_REL
        |=> next_pc_o == ($past(req_q.cond) ? $past(next_seq) + {{8{$past(req_q.op1[7])}}, $past(req_q.op1)}
                                           : $past(next_seq)))
        else $error("relative target wrong");
    AST_PAGE_TARGET: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_PAGE
        |=> next_pc_o[15:11] == $past(next_seq[15:11]) && next_pc_o[7:0] == $past(req_q.op1))
        else $error("page target wrong");
    AST_REG_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC && req_q.mode == oag_pkg::OAG_REG && req_q.cls == oag_pkg::OAG_GENERIC
        |=> cyc_left == 3'h1) else $error("register mode not single cycle");
    AST_CYC_RANGE: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_RUN |-> cyc_left >= 3'h1 && cyc_left <= 3'h5)
        else $error("cycle count out of range");
    AST_DONE_BOUND: assert property (@(posedge clk_i) disable iff (reset_i)
        state == ST_CALC |-> ##[2:21] done_o) else $error("instruction did not finish");

    COV_BRANCH_TAKEN: cover property (@(posedge clk_i) state == ST_CALC && req_q.mode == oag_pkg::OAG_REL && req_q.cond);
    COV_XMOVE_PTR: cover property (@(posedge clk_i) state == ST_CALC && req_q.mode == oag_pkg::OAG_XPTR);
    COV_FIVE_CYCLES: cover property (@(posedge clk_i) state == ST_CALC && next_cyc == 3'h5);
    COV_BIT_SFR: cover property (@(posedge clk_i) state == ST_CALC && req_q.mode == oag_pkg::OAG_BIT && req_q.op1[7]);
endmodule // oag_top

/* bench/oag_ctx_model.sv */
// core context model: accumulator, stack pointer, port latch and data pointers
`timescale 1ns/1ps
module oag_ctx_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic wr_i,
    input wire logic [2:0] sel_i,
    input wire logic [15:0] val_i,
    output logic [7:0] acc_o,
    output logic [7:0] sp_o,
    output logic [7:0] p2_o,
    output logic [15:0] data_pointer_a_o,
    output logic [15:0] data_pointer_b_o,
    output logic data_pointer_sel_o
);
    ////////////////////////////////////////////////////////////////
    // levels hold between loads, so the generator reads stable context
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_o <= 8'h00;
            sp_o <= 8'h07;
            p2_o <= 8'hff;
            data_pointer_a_o <= 16'h0000;
            data_pointer_b_o <= 16'h0000;
            data_pointer_sel_o <= 1'b0;
        end else if (wr_i) begin
            case (sel_i)
                3'h0: acc_o <= val_i[7:0];
                3'h1: sp_o <= val_i[7:0];
                3'h2: p2_o <= val_i[7:0];
                3'h3: data_pointer_a_o <= val_i;
                3'h4: data_pointer_b_o <= val_i;
                default: data_pointer_sel_o <= val_i[0];
            endcase
        end
    end
endmodule // oag_ctx_model

/* bench/oag_top_test.sv */
// self-checking bench for the operand address generator
`timescale 1ns/1ps
module oag_top_test;
    localparam logic [15:0] ONCHIP_LIM = 16'h1fff;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    oag_pkg::oag_req_t req_i = '0;
    logic [15:0] pc_i = 16'h0000;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic ram_we_i = 1'b0;
    logic [7:0] ram_addr_i = 8'h00;
    logic [7:0] ram_wdata_i = 8'h00;
    logic ctx_wr = 1'b0;
    logic [2:0] ctx_sel = 3'h0;
    logic [15:0] ctx_val = 16'h0000;
    logic [7:0] acc;
    logic [7:0] sp;
    logic [7:0] p2;
    logic [15:0] data_pointer_a;
    logic [15:0] data_pointer_b;
    logic data_pointer_sel;
    oag_pkg::oag_res_t res_o;
    logic [15:0] next_pc_o;
    logic code_onchip_o;
    logic busy_o;
    logic done_o;
    logic [7:0] program_status_word_o;
    logic ale_o;
    logic timer_tick_o;
    int err_count = 0;
    int samples_checked = 0;

    always #2.5 clk_i = ~clk_i;

    oag_top #(.ONCHIP_TOP(ONCHIP_LIM)) i_oag_top (.clk_i(clk_i), .reset_i(reset_i), .start_i(start_i),
        .req_i(req_i), .pc_i(pc_i), .acc_i(acc), .sp_i(sp), .p2_i(p2), .data_pointer_a_i(data_pointer_a), .data_pointer_b_i(data_pointer_b),
        .data_pointer_sel_i(data_pointer_sel), .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .ram_we_i(ram_we_i), .ram_addr_i(ram_addr_i), .ram_wdata_i(ram_wdata_i), .res_o(res_o),
        .next_pc_o(next_pc_o), .code_onchip_o(code_onchip_o), .busy_o(busy_o), .done_o(done_o),
        .program_status_word_o(program_status_word_o), .ale_o(ale_o), .timer_tick_o(timer_tick_o));

    oag_ctx_model i_oag_ctx_model (.clk_i(clk_i), .reset_i(reset_i), .wr_i(ctx_wr), .sel_i(ctx_sel),
        .val_i(ctx_val), .acc_o(acc), .sp_o(sp), .p2_o(p2), .data_pointer_a_o(data_pointer_a), .data_pointer_b_o(data_pointer_b),
        .data_pointer_sel_o(data_pointer_sel));

    ////////////////////////////////////////////////////////////////
    // comparison, closing report and clock stepping
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge, never on it
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr_i = 1'b1;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        tick(1);
        sfr_wr_i = 1'b0;
        tick(1);
    endtask

    task automatic ram_wr(input logic [7:0] a, input logic [7:0] d);
        ram_we_i = 1'b1;
        ram_addr_i = a;
        ram_wdata_i = d;
        tick(1);
        ram_we_i = 1'b0;
        tick(1);
    endtask

    task automatic ctx(input logic [2:0] s, input logic [15:0] v);
        ctx_wr = 1'b1;
        ctx_sel = s;
        ctx_val = v;
        tick(1);
        ctx_wr = 1'b0;
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////
    // one request: address result, next program counter and cycle budget
    task automatic op(input oag_pkg::oag_mode_t m, input oag_pkg::oag_class_t c, input logic [2:0] len,
                      input logic [2:0] rs, input logic [15:0] ops, input logic cd, input logic [15:0] pc,
                      input oag_pkg::oag_space_t sx, input logic [15:0] ad, input logic [2:0] bp,
                      input logic [15:0] np);
        oag_pkg::oag_res_t ex;
        logic [2:0] cyc;
        int n;
        ex = '{sx, ad, bp, m == oag_pkg::OAG_BIT, m == oag_pkg::OAG_TAB_PC || m == oag_pkg::OAG_TAB_PTR};
        case (c)
            oag_pkg::OAG_MULT: cyc = oag_pkg::CYC_MULT;
            oag_pkg::OAG_DIV: cyc = oag_pkg::CYC_DIV;
            oag_pkg::OAG_TABLE: cyc = oag_pkg::CYC_TABLE;
            oag_pkg::OAG_XMOVE: cyc = oag_pkg::CYC_XMOVE;
            oag_pkg::OAG_BRANCH: cyc = oag_pkg::CYC_BRANCH;
            default: cyc = (m == oag_pkg::OAG_REG) ? oag_pkg::CYC_REG : len;
        endcase
        n = 0;
        start_i = 1'b1;
        req_i = '{m, c, len, rs, ops[7:0], ops[15:8], cd};
        pc_i = pc;
        tick(1);
        start_i = 1'b0;
        // result stands from the run's first cycle, whose strobe already counts
        tick(2);
        chk(busy_o, 1'b1, "busy during run");
        if (sx != oag_pkg::OAG_SP_NONE) chk(res_o, ex, "operand address");
        chk(next_pc_o, np, "next pc");
        chk(code_onchip_o, np <= ONCHIP_LIM, "fetch side");
        for (int i = 0; i < 40 && done_o !== 1'b1; i++) begin
            if (ale_o === 1'b1) n++;
            tick(1);
        end
        if (done_o !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: no completion", $time);
            give_verdict();
        end
        chk(n, cyc, "machine cycles");
        chk(busy_o, 1'b0, "idle at done");
    endtask

    ////////////////////////////////////////////////////////////////
    // strobe spacing
    task automatic t_timing();
        int la = -1;
        int lt = -1;
        int na = 0;
        chk(program_status_word_o, oag_pkg::STATUS_RESET, "status reset");
        for (int i = 0; i < 48; i++) begin
            if (ale_o === 1'b1) begin
                if (la >= 0) chk(i - la, 4, "ale spacing");
                la = i;
                na++;
            end
            if (timer_tick_o === 1'b1) begin
                if (lt >= 0) chk(i - lt, 12, "tick spacing");
                lt = i;
            end
            tick(1);
        end
        chk(na >= 11, 1'b1, "ale count");
        $display("test timing done");
    endtask

    task automatic t_bank();
        sfr_wr(oag_pkg::STATUS_ADDR, 8'h10);
        chk(program_status_word_o, 8'h10, "status write");
        sfr_wr(8'hd1, 8'hff);
        chk(program_status_word_o, 8'h10, "other sfr ignored");
        op(oag_pkg::OAG_REG, oag_pkg::OAG_GENERIC, 3'h1, 3'h3, 16'h0000, 1'b0, 16'h0200,
           oag_pkg::OAG_SP_IRAM, 16'h0013, 3'h0, 16'h0201);
        sfr_wr(oag_pkg::STATUS_ADDR, 8'h18);
        op(oag_pkg::OAG_REG, oag_pkg::OAG_GENERIC, 3'h1, 3'h7, 16'h0000, 1'b0, 16'h0201,
           oag_pkg::OAG_SP_IRAM, 16'h001f, 3'h0, 16'h0202);
        $display("test bank done");
    endtask

    task automatic t_direct_bit();
        op(oag_pkg::OAG_DIRECT, oag_pkg::OAG_GENERIC, 3'h3, 3'h0, 16'h007f, 1'b0, 16'h0300,
           oag_pkg::OAG_SP_IRAM, 16'h007f, 3'h0, 16'h0303);
        op(oag_pkg::OAG_DIRECT, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h0080, 1'b0, 16'h0303,
           oag_pkg::OAG_SP_SFR, 16'h0080, 3'h0, 16'h0305);
        op(oag_pkg::OAG_BIT, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h0000, 1'b0, 16'h0305,
           oag_pkg::OAG_SP_IRAM, 16'h0020, 3'h0, 16'h0307);
        op(oag_pkg::OAG_BIT, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h007f, 1'b0, 16'h0307,
           oag_pkg::OAG_SP_IRAM, 16'h002f, 3'h7, 16'h0309);
        op(oag_pkg::OAG_BIT, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h00b7, 1'b0, 16'h0309,
           oag_pkg::OAG_SP_SFR, 16'h00b0, 3'h7, 16'h030b);
        $display("test direct and bit done");
    endtask

    task automatic t_indirect();
        ram_wr(8'h19, 8'h9a);
        ram_wr(8'h18, 8'h67);
        ctx(3'h1, 16'h005e);
        ctx(3'h2, 16'h0045);
        ctx(3'h3, 16'h1234);
        ctx(3'h4, 16'hbeef);
        ctx(3'h5, 16'h0001);
        op(oag_pkg::OAG_INDIRECT, oag_pkg::OAG_GENERIC, 3'h1, 3'h1, 16'h0000, 1'b0, 16'h0400,
           oag_pkg::OAG_SP_IRAM, 16'h009a, 3'h0, 16'h0401);
        op(oag_pkg::OAG_XRI, oag_pkg::OAG_XMOVE, 3'h1, 3'h0, 16'h0000, 1'b0, 16'h0401,
           oag_pkg::OAG_SP_XDATA, 16'h4567, 3'h0, 16'h0402);
        op(oag_pkg::OAG_STACK, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h0000, 1'b0, 16'h0402,
           oag_pkg::OAG_SP_IRAM, 16'h005e, 3'h0, 16'h0404);
        op(oag_pkg::OAG_XPTR, oag_pkg::OAG_XMOVE, 3'h1, 3'h0, 16'h0000, 1'b0, 16'h0404,
           oag_pkg::OAG_SP_XDATA, 16'hbeef, 3'h0, 16'h0405);
        ctx(3'h5, 16'h0000);
        op(oag_pkg::OAG_XPTR, oag_pkg::OAG_XMOVE, 3'h1, 3'h0, 16'h0000, 1'b0, 16'h0405,
           oag_pkg::OAG_SP_XDATA, 16'h1234, 3'h0, 16'h0406);
        $display("test indirect done");
    endtask

    task automatic t_table();
        ctx(3'h0, 16'h0080);
        op(oag_pkg::OAG_IMM, oag_pkg::OAG_GENERIC, 3'h2, 3'h0, 16'h0040, 1'b0, 16'h0500,
           oag_pkg::OAG_SP_IMM, 16'h0040, 3'h0, 16'h0502);
        op(oag_pkg::OAG_TAB_PC, oag_pkg::OAG_TABLE, 3'h1, 3'h0, 16'h0000, 1'b0, 16'h0ffe,
           oag_pkg::OAG_SP_CODE, 16'h107f, 3'h0, 16'h0fff);
        op(oag_pkg::OAG_TAB_PTR, oag_pkg::OAG_TABLE, 3'h1, 3'h0, 16'h0000, 1'b0, 16'h0fff,
           oag_pkg::OAG_SP_CODE, 16'h12b4, 3'h0, 16'h1000);
        $display("test table done");
    endtask

    task automatic t_branch();
        op(oag_pkg::OAG_REL, oag_pkg::OAG_BRANCH, 3'h2, 3'h0, 16'h00ec, 1'b1, 16'h0100,
           oag_pkg::OAG_SP_NONE, 16'h0000, 3'h0, 16'h00ee);
        op(oag_pkg::OAG_REL, oag_pkg::OAG_BRANCH, 3'h2, 3'h0, 16'h00ec, 1'b0, 16'h0100,
           oag_pkg::OAG_SP_NONE, 16'h0000, 3'h0, 16'h0102);
        op(oag_pkg::OAG_REL, oag_pkg::OAG_BRANCH, 3'h3, 3'h0, 16'h007f, 1'b1, 16'h1ffd,
           oag_pkg::OAG_SP_NONE, 16'h0000, 3'h0, 16'h207f);
        op(oag_pkg::OAG_PAGE, oag_pkg::OAG_BRANCH, 3'h2, 3'h0, 16'h07ff, 1'b0, 16'h27fe,
           oag_pkg::OAG_SP_NONE, 16'h0000, 3'h0, 16'h2fff);
        op(oag_pkg::OAG_LONG, oag_pkg::OAG_BRANCH, 3'h3, 3'h0, 16'hf732, 1'b0, 16'h0100,
           oag_pkg::OAG_SP_NONE, 16'h0000, 3'h0, 16'hf732);
        $display("test branch done");
    endtask

    task automatic t_cycles();
        op(oag_pkg::OAG_IMM, oag_pkg::OAG_MULT, 3'h1, 3'h0, 16'h0011, 1'b0, 16'h0600,
           oag_pkg::OAG_SP_IMM, 16'h0011, 3'h0, 16'h0601);
        op(oag_pkg::OAG_IMM, oag_pkg::OAG_DIV, 3'h1, 3'h0, 16'h0022, 1'b0, 16'h0601,
           oag_pkg::OAG_SP_IMM, 16'h0022, 3'h0, 16'h0602);
        op(oag_pkg::OAG_IMM, oag_pkg::OAG_GENERIC, 3'h5, 3'h0, 16'h0033, 1'b0, 16'h0602,
           oag_pkg::OAG_SP_IMM, 16'h0033, 3'h0, 16'h0607);
        $display("test cycles done");
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(3);
        chk(ale_o, 1'b0, "ale held in reset");
        reset_i = 1'b0;
        t_timing();
        t_bank();
        t_direct_bit();
        t_indirect();
        t_table();
        t_branch();
        t_cycles();
        give_verdict();
    end
endmodule // oag_top_test
